// ### hw/dtp_pkg.sv
package dtp_pkg;
	// register byte addresses on the APB bus
	localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'h08;
	localparam logic [7:0] ADDR_DUTY_LOW = 8'h0C;
	localparam logic [7:0] ADDR_HIGH_BITS = 8'h10;
	localparam logic [7:0] ADDR_PRESCALER_COUNT = 8'h14;
	localparam logic [7:0] ADDR_BUZZER_CONTROL = 8'h18;
	localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h1C;
	localparam logic [7:0] ADDR_INTERRUPT_ENABLES = 8'h20;
	localparam logic [7:0] ADDR_GLOBAL_CONTROL = 8'h24;
	localparam logic [7:0] ADDR_COUNT_VALUE = 8'h28;

	// counter_control_one fields
	localparam int BIT_PWM_OUTPUT_ENABLE = 7;
	localparam int BIT_PWM_ACTIVE_LOW = 6;
	localparam int BIT_ONE_SHOT_SELECT = 2;
	localparam int BIT_RELOAD_SELECT = 1;
	localparam int BIT_COUNTER_ENABLE = 0;
	// counter_control_two fields
	localparam int BIT_CLOCK_SOURCE_SELECT = 5;
	localparam int BIT_EXTERNAL_EDGE_SELECT = 4;
	localparam int BIT_PRESCALER_ENABLE_N = 3;
	localparam int POS_PRESCALER_RATIO = 0;
	// reload_duty_high_bits fields
	localparam int POS_RELOAD_HIGH = 4;
	localparam int POS_DUTY_HIGH = 0;
	// buzzer_control fields
	localparam int BIT_BUZZER_ENABLE = 7;
	localparam int POS_BUZZER_FREQ_SELECT = 0;
	// flag, enable and global bits
	localparam int BIT_UNDERFLOW_FLAG = 3;
	localparam int BIT_UNDERFLOW_IRQ_ENABLE = 3;
	localparam int BIT_GLOBAL_IRQ_ENABLE = 0;

	// reset values and the free-run restart value
	localparam logic [7:0] RESET_CONTROL_ONE = 8'h00;
	localparam logic [7:0] RESET_CONTROL_TWO = 8'h08;
	localparam logic [7:0] RESET_HIGH_BITS = 8'h00;
	localparam logic [7:0] RESET_BUZZER_CONTROL = 8'h0F;
	localparam logic [9:0] RESET_COUNT = 10'h3FF;
	localparam logic [9:0] RESET_RELOAD = 10'h3FF;
	localparam logic [9:0] RESET_DUTY = 10'h000;
	localparam logic [7:0] RESET_PRESCALER = 8'hFF;
	localparam logic [9:0] FREE_RUN_START = 10'h3FF;

	typedef struct packed {
		logic drive;
		logic level;
	} dtp_pin_t;
endpackage : dtp_pkg

// ### hw/dtp_timer.sv
// Behaviour
// - a 10-bit down-counter behind a prescaler feeds both pwm and buzzer outputs
// - high reload bits first, low byte commits; when enabled, load waits for underflow
// - with the counter disabled, a low reload byte write loads the counter at once
// - reading the counter register returns the live count, not the reload value
// - counting runs only while counter_enable is set
// - clock_source_select 1 picks the external pin, 0 the instruction clock
// - external_edge_select 1 counts falling edges, 0 counts rising edges
// - prescaler_enable_n 0 enables the prescaler; ratio divides 1:2 to 1:256
// - the prescaler count is readable
// - one-shot counts down once to zero, flags underflow, then stops
// - continuous mode restarts from reload value or 0x3FF per reload_select
// - each underflow sets the flag; irq needs both enables set
// - the flag stays set until software writes 0 to it
// - pwm enable drives pwm onto the shared pin as an output
// - pwm_active_low 1 makes pwm active low, 0 active high
// - duty sets active clocks per frame; 0 never active, 0x3FF gives 1023
// - high duty bits first, low byte stages; when enabled, new duty applies after underflow
// - buzzer enable drives buzzer onto the shared pin as an output
// - buzzer select top bit picks prescaler (0) or counter (1) as source
// - pwm wins over buzzer on the shared pin
// - buzzer select 0-7 is prescaler 1:2..1:256, 8-15 counter bits 0..7
// - shared pin priority: comparator, then pwm, then buzzer
//
// Added by the designer: the address map and register access over APB.
module dtp_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic external_count_clock,
	input wire logic comparator_out_enable,
	input wire logic comparator_out,
	output logic shared_output_pin_o,
	output logic shared_output_pin_oe,
	output logic irq
);
	logic [7:0] counter_control_one;
	logic [7:0] counter_control_two;
	logic [7:0] reload_duty_high_bits;
	logic [7:0] buzzer_control;
	logic underflow_flag;
	logic underflow_irq_enable;
	logic global_irq_enable;
	logic [9:0] reload_value;
	logic [9:0] duty_staged;
	logic [9:0] duty_active;
	logic [9:0] count;
	logic [7:0] prescaler_count_value;
	logic one_shot_done;
	logic ext_sync1;
	logic ext_sync2;
	logic ext_prev;
	dtp_pkg::dtp_pin_t pin;

	// prescaler bits that must all be set for a tick: ratio 0 needs bit 0, ratio 7 needs all eight
	function automatic logic [(2 ** 3) - 1:0] ratio_mask(input logic [2:0] sel);
		ratio_mask = 8'(({1'b0, 8'hFF} >> (3'h7 - sel)));
	endfunction : ratio_mask

	// bus decode
	wire setup_phase = psel & ~penable;
	wire bus_write = psel & penable & pready & pwrite & pstrb[0];
	wire [7:0] wbyte = pwdata[7:0];
	wire wr_control_one = bus_write & (paddr == dtp_pkg::ADDR_CONTROL_ONE);
	wire wr_control_two = bus_write & (paddr == dtp_pkg::ADDR_CONTROL_TWO);
	wire wr_reload_low = bus_write & (paddr == dtp_pkg::ADDR_RELOAD_LOW);
	wire wr_duty_low = bus_write & (paddr == dtp_pkg::ADDR_DUTY_LOW);
	wire wr_high_bits = bus_write & (paddr == dtp_pkg::ADDR_HIGH_BITS);
	wire wr_buzzer = bus_write & (paddr == dtp_pkg::ADDR_BUZZER_CONTROL);
	wire wr_flags = bus_write & (paddr == dtp_pkg::ADDR_INTERRUPT_FLAGS);
	wire wr_enables = bus_write & (paddr == dtp_pkg::ADDR_INTERRUPT_ENABLES);
	wire wr_global = bus_write & (paddr == dtp_pkg::ADDR_GLOBAL_CONTROL);

	// control fields
	wire counter_enable = counter_control_one[dtp_pkg::BIT_COUNTER_ENABLE];
	wire one_shot_select = counter_control_one[dtp_pkg::BIT_ONE_SHOT_SELECT];
	wire reload_select = counter_control_one[dtp_pkg::BIT_RELOAD_SELECT];
	wire pwm_output_enable = counter_control_one[dtp_pkg::BIT_PWM_OUTPUT_ENABLE];
	wire pwm_active_low = counter_control_one[dtp_pkg::BIT_PWM_ACTIVE_LOW];
	wire clock_source_select = counter_control_two[dtp_pkg::BIT_CLOCK_SOURCE_SELECT];
	wire external_edge_select = counter_control_two[dtp_pkg::BIT_EXTERNAL_EDGE_SELECT];
	wire prescaler_enable_n = counter_control_two[dtp_pkg::BIT_PRESCALER_ENABLE_N];
	wire [2:0] prescaler_ratio = counter_control_two[dtp_pkg::POS_PRESCALER_RATIO +: 3];
	wire buzzer_enable = buzzer_control[dtp_pkg::BIT_BUZZER_ENABLE];
	wire [3:0] buzzer_freq_select = buzzer_control[dtp_pkg::POS_BUZZER_FREQ_SELECT +: 4];
	wire [1:0] reload_high = reload_duty_high_bits[dtp_pkg::POS_RELOAD_HIGH +: 2];
	wire [1:0] duty_high = reload_duty_high_bits[dtp_pkg::POS_DUTY_HIGH +: 2];

	// clock source and edge; only the second sync stage feeds logic
	wire ext_rise = ext_sync2 & ~ext_prev;
	wire ext_fall = ~ext_sync2 & ext_prev;
	wire ext_edge = external_edge_select ? ext_fall : ext_rise;
	wire source_tick = clock_source_select ? ext_edge : 1'b1;
	wire running = counter_enable & ~one_shot_done;

	// prescaler: tick once every 2^(ratio+1) source ticks
	wire [7:0] mask = ratio_mask(prescaler_ratio);
	wire prescaler_wrap = (prescaler_count_value & mask) == mask;
	wire counter_tick = running & source_tick & (prescaler_enable_n | prescaler_wrap);
	wire underflow = counter_tick & (count == 10'h000);

	// next count on a tick
	wire [9:0] restart_value = reload_select ? reload_value : dtp_pkg::FREE_RUN_START;
	wire [9:0] next_count = underflow ? (one_shot_select ? count : restart_value) : count - 10'h001;

	// pwm: active while the count sits below duty, so duty clocks per frame
	wire pwm_active = count < duty_active;
	wire pwm_level = pwm_active ^ pwm_active_low;

	// buzzer: prescaler bit n gives 1:2^(n+1); counter bit n otherwise
	wire buzzer_level = buzzer_freq_select[3] ? count[buzzer_freq_select[2:0]]
		: prescaler_count_value[buzzer_freq_select[2:0]];

	// shared pin priority
	wire next_pin_drive = comparator_out_enable | pwm_output_enable | buzzer_enable;
	wire next_pin_level = comparator_out_enable ? comparator_out
		: pwm_output_enable ? pwm_level : buzzer_level;

	// read mux
	wire [9:0] reload_next = {reload_high, wbyte};
	logic [31:0] next_rdata;
	logic next_err;
	always_comb begin
		next_err = 1'b0;
		case (paddr)
			dtp_pkg::ADDR_CONTROL_ONE: next_rdata = {24'h000000, counter_control_one};
			dtp_pkg::ADDR_CONTROL_TWO: next_rdata = {24'h000000, counter_control_two};
			dtp_pkg::ADDR_RELOAD_LOW: next_rdata = {24'h000000, count[7:0]};
			dtp_pkg::ADDR_DUTY_LOW: next_rdata = {24'h000000, duty_staged[7:0]};
			dtp_pkg::ADDR_HIGH_BITS: next_rdata = {24'h000000, reload_duty_high_bits};
			dtp_pkg::ADDR_PRESCALER_COUNT: next_rdata = {24'h000000, prescaler_count_value};
			dtp_pkg::ADDR_BUZZER_CONTROL: next_rdata = {24'h000000, buzzer_control};
			dtp_pkg::ADDR_INTERRUPT_FLAGS: next_rdata = 32'(underflow_flag) << dtp_pkg::BIT_UNDERFLOW_FLAG;
			dtp_pkg::ADDR_INTERRUPT_ENABLES: next_rdata = 32'(underflow_irq_enable) << dtp_pkg::BIT_UNDERFLOW_IRQ_ENABLE;
			dtp_pkg::ADDR_GLOBAL_CONTROL: next_rdata = 32'(global_irq_enable) << dtp_pkg::BIT_GLOBAL_IRQ_ENABLE;
			dtp_pkg::ADDR_COUNT_VALUE: next_rdata = {22'h0, count};
			default: begin
				next_rdata = 32'h00000000;
				next_err = 1'b1;
			end
		endcase
	end

	// apb slave: one wait-free access phase, answer set up from the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_phase;
			prdata <= (setup_phase & ~pwrite) ? next_rdata : 32'h00000000;
			pslverr <= setup_phase & next_err;
		end
	end

	// control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_control_one <= dtp_pkg::RESET_CONTROL_ONE;
			counter_control_two <= dtp_pkg::RESET_CONTROL_TWO;
			reload_duty_high_bits <= dtp_pkg::RESET_HIGH_BITS;
			buzzer_control <= dtp_pkg::RESET_BUZZER_CONTROL;
			underflow_irq_enable <= 1'b0;
			global_irq_enable <= 1'b0;
		end else begin
			if (wr_control_one)
				counter_control_one <= wbyte;
			if (wr_control_two)
				counter_control_two <= wbyte;
			if (wr_high_bits)
				reload_duty_high_bits <= wbyte;
			if (wr_buzzer)
				buzzer_control <= wbyte;
			if (wr_enables)
				underflow_irq_enable <= wbyte[dtp_pkg::BIT_UNDERFLOW_IRQ_ENABLE];
			if (wr_global)
				global_irq_enable <= wbyte[dtp_pkg::BIT_GLOBAL_IRQ_ENABLE];
		end
	end

	// reload and duty buffers; the low byte write commits the high bits staged earlier
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_value <= dtp_pkg::RESET_RELOAD;
			duty_staged <= dtp_pkg::RESET_DUTY;
			duty_active <= dtp_pkg::RESET_DUTY;
		end else begin
			if (wr_reload_low)
				reload_value <= reload_next;
			if (wr_duty_low)
				duty_staged <= {duty_high, wbyte};
			// a disabled counter has no underflow to wait for, so duty follows at once
			if (underflow | ~counter_enable)
				duty_active <= duty_staged;
		end
	end

	// counter, prescaler and one-shot stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= dtp_pkg::RESET_COUNT;
			prescaler_count_value <= dtp_pkg::RESET_PRESCALER;
			one_shot_done <= 1'b0;
		end else begin
			if (wr_reload_low & ~counter_enable)
				count <= reload_next;
			else if (counter_tick)
				count <= next_count;
			if (running & source_tick & ~prescaler_enable_n)
				prescaler_count_value <= prescaler_count_value + 8'h01;
			// rewriting control one rearms a finished one-shot
			if (wr_control_one)
				one_shot_done <= 1'b0;
			else if (underflow & one_shot_select)
				one_shot_done <= 1'b1;
		end
	end

	// underflow flag: the set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			underflow_flag <= 1'b0;
		else if (underflow)
			underflow_flag <= 1'b1;
		else if (wr_flags & ~wbyte[dtp_pkg::BIT_UNDERFLOW_FLAG])
			underflow_flag <= 1'b0;
	end

	// external clock synchroniser and edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync1 <= 1'b0;
			ext_sync2 <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_sync1 <= external_count_clock;
			ext_sync2 <= ext_sync1;
			ext_prev <= ext_sync2;
		end
	end

	// registered pin and interrupt outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin <= '0;
			irq <= 1'b0;
		end else begin
			pin <= '{drive: next_pin_drive, level: next_pin_level};
			irq <= underflow_flag & underflow_irq_enable & global_irq_enable;
		end
	end

	assign shared_output_pin_o = pin.level;
	assign shared_output_pin_oe = pin.drive;
endmodule : dtp_timer

// ### verif/dtp_ext_src.sv
module dtp_ext_src (
	output logic external_count_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	initial external_count_clock = 1'b0;
	// ends high: one falling edge fewer than rising, so the two edge settings read apart
	task automatic burst(input int n);
		repeat (n - 1) begin
			#70 external_count_clock = 1'b1;
			#70 external_count_clock = 1'b0;
		end
		#70 external_count_clock = 1'b1;
	endtask : burst
	task automatic idle();
		#70 external_count_clock = 1'b0;
	endtask : idle
endmodule : dtp_ext_src

// ### verif/dtp_timer_chk.sv
module dtp_timer_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic comparator_out_enable,
	input wire logic comparator_out,
	input wire logic shared_output_pin_o,
	input wire logic shared_output_pin_oe,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && pready; endsequence
	chk_setup_gets_ready: assert property (s_setup |=> s_access)
		else $error("no ready after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_ready_cause: assert property ($rose(pready) |-> $past(psel && !penable))
		else $error("ready without setup");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("error outside access");
	chk_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	chk_cmp_drive: assert property (comparator_out_enable |=> shared_output_pin_oe)
		else $error("comparator not driving pin");
	chk_cmp_level: assert property (comparator_out_enable |=> shared_output_pin_o == $past(comparator_out))
		else $error("pin level not comparator");
	// an irq can only drop after a register write has cleared the flag or an enable
	chk_flag_sticky: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 2))
		else $error("irq dropped without a write");
endmodule : dtp_timer_chk
bind dtp_timer dtp_timer_chk dtp_timer_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr), .comparator_out(comparator_out),
	.comparator_out_enable(comparator_out_enable), .shared_output_pin_o(shared_output_pin_o),
	.shared_output_pin_oe(shared_output_pin_oe), .irq(irq));

// ### verif/test_dtp_timer.sv
module test_dtp_timer;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic cmp_en = 1'b0;
	logic cmp_val = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdata;
	logic pready, pslverr, pin_o, pin_oe, irq, ext_clk, rerr;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 91836;
	int t, h;
	logic [9:0] rv;
	always #10 pclk = ~pclk;
	dtp_timer dtp_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.external_count_clock(ext_clk), .comparator_out_enable(cmp_en), .comparator_out(cmp_val),
		.shared_output_pin_o(pin_o), .shared_output_pin_oe(pin_oe), .irq(irq));
	dtp_ext_src dtp_ext_src_i (.external_count_clock(ext_clk));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	// the request stands until the rising edge that sees pready; only the bench timeout ends a hung wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rdata, exp);
	endtask : rd
	function automatic logic [31:0] toggles(input int shift);
		return 32'(512 >> shift);
	endfunction : toggles
	// counts pin changes and high cycles; the first cycles are skipped so the pin pipeline settles
	task automatic meas(input int len);
		logic last;
		t = 0;
		h = 0;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		last = pin_o;
		repeat (len) begin
			@(negedge pclk);
			t += int'(pin_o !== last);
			h += int'(pin_o === 1'b1);
			last = pin_o;
		end
	endtask : meas
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			stop_test();
		end
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(dtp_pkg::ADDR_CONTROL_TWO, 32'h08);
		rd(dtp_pkg::ADDR_BUZZER_CONTROL, 32'h0F);
		rd(dtp_pkg::ADDR_COUNT_VALUE, 32'h3FF);
		rd(dtp_pkg::ADDR_PRESCALER_COUNT, 32'hFF);
		apb(1'b0, 8'h3C, 32'h0);
		check({rdata[30:0], rerr}, 32'h1);
		repeat (4) begin
			rv = 10'($random(seed));
			wr(dtp_pkg::ADDR_HIGH_BITS, 32'({rv[9:8], 4'h0}));
			wr(dtp_pkg::ADDR_RELOAD_LOW, 32'(rv[7:0]));
			rd(dtp_pkg::ADDR_COUNT_VALUE, 32'(rv));
			rd(dtp_pkg::ADDR_RELOAD_LOW, 32'(rv[7:0]));
		end
		wr(dtp_pkg::ADDR_HIGH_BITS, 32'h0);
		wr(dtp_pkg::ADDR_RELOAD_LOW, 32'h05);
		wr(dtp_pkg::ADDR_INTERRUPT_ENABLES, 32'h08);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h05);
		repeat (20) @(posedge pclk);
		rd(dtp_pkg::ADDR_COUNT_VALUE, 32'h0);
		rd(dtp_pkg::ADDR_INTERRUPT_FLAGS, 32'h08);
		check(32'(irq), 32'h0);
		wr(dtp_pkg::ADDR_GLOBAL_CONTROL, 32'h1);
		repeat (2) @(negedge pclk);
		check(32'(irq), 32'h1);
		wr(dtp_pkg::ADDR_INTERRUPT_FLAGS, 32'h08);
		rd(dtp_pkg::ADDR_INTERRUPT_FLAGS, 32'h08);
		wr(dtp_pkg::ADDR_INTERRUPT_FLAGS, 32'h0);
		rd(dtp_pkg::ADDR_INTERRUPT_FLAGS, 32'h0);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h0);
		wr(dtp_pkg::ADDR_RELOAD_LOW, 32'h03);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h01);
		repeat (4) @(posedge pclk);
		apb(1'b0, dtp_pkg::ADDR_COUNT_VALUE, 32'h0);
		check(32'(rdata[9:0] > 10'h3F0), 32'h1);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h03);
		repeat (1100) @(posedge pclk);
		apb(1'b0, dtp_pkg::ADDR_COUNT_VALUE, 32'h0);
		check(32'(rdata[9:0] <= 10'h3), 32'h1);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h0);
		wr(dtp_pkg::ADDR_HIGH_BITS, 32'h33);
		wr(dtp_pkg::ADDR_RELOAD_LOW, 32'hFF);
		wr(dtp_pkg::ADDR_DUTY_LOW, 32'hFF);
		wr(dtp_pkg::ADDR_BUZZER_CONTROL, 32'h88);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h81);
		meas(1024);
		check(32'(h), 32'h3FF);
		check(32'(pin_oe), 32'h1);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'hC1);
		meas(1024);
		check(32'(h), 32'h1);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h0);
		wr(dtp_pkg::ADDR_HIGH_BITS, 32'h30);
		wr(dtp_pkg::ADDR_RELOAD_LOW, 32'hFF);
		wr(dtp_pkg::ADDR_DUTY_LOW, 32'h0);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h81);
		meas(1024);
		check(32'(h), 32'h0);
		// duty staged while running waits for the next underflow, about 1024 clocks away
		wr(dtp_pkg::ADDR_HIGH_BITS, 32'h33);
		wr(dtp_pkg::ADDR_DUTY_LOW, 32'hFF);
		meas(200);
		check(32'(h), 32'h0);
		repeat (850) @(posedge pclk);
		meas(1024);
		check(32'(h), 32'h3FF);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h01);
		for (int r = 0; r < 8; r++) begin
			wr(dtp_pkg::ADDR_CONTROL_TWO, 32'(r));
			meas(512);
			check(32'(t), toggles(r + 1));
		end
		// ratio 0: the counter ticks every other clock, so its bit k toggles like prescaler bit k+1
		wr(dtp_pkg::ADDR_CONTROL_TWO, 32'h0);
		for (int s = 0; s < 16; s++) begin
			wr(dtp_pkg::ADDR_BUZZER_CONTROL, 32'(8'h80 | s));
			meas(512);
			check(32'(t), toggles(s < 8 ? s : s - 7));
		end
		check(32'(pin_oe), 32'h1);
		@(posedge pclk);
		cmp_en <= 1'b1;
		repeat (6) begin
			@(posedge pclk);
			cmp_val <= 1'($random(seed));
			@(negedge pclk);
			@(negedge pclk);
			check(32'(pin_o), 32'(cmp_val));
		end
		@(posedge pclk);
		cmp_en <= 1'b0;
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h0);
		wr(dtp_pkg::ADDR_CONTROL_TWO, 32'h28);
		wr(dtp_pkg::ADDR_HIGH_BITS, 32'h10);
		wr(dtp_pkg::ADDR_RELOAD_LOW, 32'h0);
		wr(dtp_pkg::ADDR_CONTROL_ONE, 32'h01);
		dtp_ext_src_i.burst(5);
		repeat (10) @(posedge pclk);
		rd(dtp_pkg::ADDR_COUNT_VALUE, 32'h0FB);
		wr(dtp_pkg::ADDR_RELOAD_LOW, 32'h50);
		rd(dtp_pkg::ADDR_RELOAD_LOW, 32'hFB);
		dtp_ext_src_i.idle();
		repeat (10) @(posedge pclk);
		rd(dtp_pkg::ADDR_COUNT_VALUE, 32'h0FB);
		wr(dtp_pkg::ADDR_CONTROL_TWO, 32'h38);
		dtp_ext_src_i.burst(5);
		repeat (10) @(posedge pclk);
		rd(dtp_pkg::ADDR_COUNT_VALUE, 32'h0F7);
		stop_test();
	end
endmodule : test_dtp_timer
